// ===== hw/frf_pkg.sv
// How it works
// - Byte 0 of every response echoes the read-flash-data code.
// - Byte 1 is status: zero on success, one when unsupported.
// - Byte 2 holds structure length; meaningless when nothing returned.
// - Bytes 3 to 63 carry payload set by sub-command and status.
// - Byte 4 bit 7 enables the serial-number descriptor.
// - Byte 4 bits 1-0: locked, password-protected or unsecured.
// - Byte 5 bits 4-0 divide the clock driven on the clock pin.
// - Byte 6 bits 7-6 pick the output converter reference level.
// - Byte 6 bit 5: one internal reference, zero supply.
// - Byte 6 bits 4-0 give the output converter power-up value.
// - Byte 7 bit 6 lets falling input edges set the detect flag.
// - Byte 7 bit 5 lets rising input edges set the detect flag.
// - Byte 7 bits 4-3 pick the input converter reference level.
// - Byte 7 bit 2: one supply, zero internal reference.
// - Bytes 8 and 9 give the vendor identifier, low byte first.
// - Any unsupported sub-code gets the unsupported status.
package frf_pkg;
  localparam logic [7:0] CMD_RDFLASH = 8'hb0;
  localparam logic [7:0] SUB_CHIP = 8'h00;
  localparam logic [7:0] ST_OK = 8'h00;
  localparam logic [7:0] ST_UNSUP = 8'h01;
  localparam logic [5:0] IDX_CMD = 6'h00;
  localparam logic [5:0] IDX_ST = 6'h01;
  localparam logic [5:0] IDX_LEN = 6'h02;
  localparam logic [5:0] IDX_SET4 = 6'h04;
  localparam logic [5:0] IDX_SET5 = 6'h05;
  localparam logic [5:0] IDX_SET6 = 6'h06;
  localparam logic [5:0] IDX_SET7 = 6'h07;
  localparam logic [5:0] IDX_VIDL = 6'h08;
  localparam logic [5:0] IDX_VIDH = 6'h09;
  localparam logic [5:0] IDX_LAST = 6'h3f;
  localparam logic [3:0] A_SET4 = 4'h0;
  localparam logic [3:0] A_SET5 = 4'h1;
  localparam logic [3:0] A_SET6 = 4'h2;
  localparam logic [3:0] A_SET7 = 4'h3;
  localparam logic [3:0] A_VIDL = 4'h4;
  localparam logic [3:0] A_VIDH = 4'h5;
  localparam logic [3:0] A_LEN = 4'h6;
  localparam logic [3:0] A_STAT = 4'h7;
  localparam logic [3:0] A_MASK = 4'h8;
  localparam logic [3:0] A_CTRL = 4'h9;
  localparam logic [3:0] A_STATE = 4'ha;
  localparam logic [7:0] M_SET4 = 8'h83;
  localparam logic [7:0] M_SET5 = 8'h1f;
  localparam logic [7:0] M_SET7 = 8'h7c;
  localparam logic [7:0] M_EVT = 8'h07;
  localparam logic [7:0] RST_SET = 8'h00;
  localparam logic [7:0] RST_VIDL = 8'h00;
  localparam logic [7:0] RST_VIDH = 8'h00;
  localparam logic [7:0] RST_LEN = 8'h00;
  localparam int EV_DONE = 0;
  localparam int EV_UNSUP = 1;
  localparam int EV_EDGE = 2;
  localparam int B_SER = 7;
  localparam int B_LOCK = 1;
  localparam int B_PWD = 0;
  localparam int B_DINT = 5;
  localparam int B_FALL = 6;
  localparam int B_RISE = 5;
  localparam int B_ASUP = 2;
  localparam logic [4:0] DIV_ONE = 5'h01;

  typedef enum logic {S_IDLE, S_SEND} frf_st_t;

  typedef struct packed {
    logic valid;
    logic [7:0] code;
    logic [7:0] sub;
  } frf_cmd_t;

  typedef struct packed {
    logic valid;
    logic last;
    logic [5:0] idx;
    logic [7:0] data;
  } frf_rsp_t;

  typedef struct packed {
    logic serial_en;
    logic sec_locked;
    logic sec_password;
    logic [1:0] dac_lvl;
    logic dac_internal;
    logic [4:0] dac_powerup;
    logic [1:0] adc_lvl;
    logic adc_supply;
  } frf_cfg_t;
endpackage : frf_pkg

// ===== hw/frf_top.sv
// Added by the designer: the register offsets and the address-and-strobe port.
`timescale 1ns/10ps
module frf_top (
  input wire logic CLK,
  input wire logic RST,
  input wire frf_pkg::frf_cmd_t CMD,
  output logic CMD_READY,
  output frf_pkg::frf_rsp_t RSP,
  input wire logic [3:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  input wire logic INT_PIN,
  output logic CLK_OUT,
  output frf_pkg::frf_cfg_t CFG,
  output logic IRQ
);
  import frf_pkg::*;

  function automatic logic [7:0] rsp_byte(
    input logic [5:0] i,
    input logic ok,
    input logic [7:0] len,
    input logic [7:0] s4,
    input logic [7:0] s5,
    input logic [7:0] s6,
    input logic [7:0] s7,
    input logic [15:0] vendor_identifier
  );
    logic [7:0] b;
    b = 8'h00;
    unique case (i)
      IDX_CMD: b = CMD_RDFLASH;
      IDX_ST: b = ok ? ST_OK : ST_UNSUP;
      IDX_LEN: b = ok ? len : 8'h00;
      IDX_SET4: b = ok ? s4 : 8'h00;
      IDX_SET5: b = ok ? s5 : 8'h00;
      IDX_SET6: b = ok ? s6 : 8'h00;
      IDX_SET7: b = ok ? s7 : 8'h00;
      IDX_VIDL: b = ok ? vendor_identifier[7:0] : 8'h00;
      IDX_VIDH: b = ok ? vendor_identifier[15:8] : 8'h00;
      default: b = 8'h00;
    endcase
    return b;
  endfunction : rsp_byte

  frf_st_t st_r, st_nxt;
  logic ready_r;
  logic ok_r;
  logic [5:0] idx_r;
  frf_rsp_t rsp_r, rsp_nxt;
  logic [7:0] set4_r, set5_r, set6_r, set7_r;
  logic [7:0] vidl_r, vidh_r, len_r;
  logic [7:0] stat_r, stat_nxt, mask_r;
  logic clko_en_r;
  logic [7:0] rdata_r, rdata_nxt;
  logic irq_r;
  logic int_s1_r, int_s2_r, int_s3_r;
  logic [4:0] div_cnt_r;
  logic clk_out_r;
  frf_cfg_t cfg_r, cfg_nxt;

  wire accept = CMD.valid && ready_r && CMD.code == CMD_RDFLASH;
  wire sub_ok = CMD.sub == SUB_CHIP;
  wire send_end = st_r == S_SEND && idx_r == IDX_LAST;
  wire rise = int_s2_r && !int_s3_r;
  wire fall = !int_s2_r && int_s3_r;
  wire edge_hit = (rise && set7_r[B_RISE]) || (fall && set7_r[B_FALL]);
  wire wr_stat = WR && ADDR == A_STAT;
  wire [7:0] evt = {5'h00, edge_hit, accept && !sub_ok, send_end};
  wire [7:0] byte_sel = rsp_byte(idx_r, ok_r, len_r, set4_r, set5_r,
                                 set6_r, set7_r, {vidh_r, vidl_r});
  wire div_wrap = div_cnt_r >= set5_r[4:0] - DIV_ONE;

  // Sequencer: one full report per accepted command
  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      S_IDLE: if (accept) begin
        st_nxt = S_SEND;
      end
      S_SEND: if (send_end) begin
        st_nxt = S_IDLE;
      end
    endcase
  end

  always_comb begin
    rsp_nxt = '0;
    if (st_r == S_SEND) begin
      rsp_nxt.valid = 1'b1;
      rsp_nxt.last = idx_r == IDX_LAST;
      rsp_nxt.idx = idx_r;
      rsp_nxt.data = byte_sel;
    end
  end

  // Set wins over a write-one clear
  assign stat_nxt = (stat_r & ~(wr_stat ? WDATA : 8'h00)) | evt;

  always_comb begin
    rdata_nxt = 8'h00;
    if (RD) begin
      unique case (ADDR)
        A_SET4: rdata_nxt = set4_r;
        A_SET5: rdata_nxt = set5_r;
        A_SET6: rdata_nxt = set6_r;
        A_SET7: rdata_nxt = set7_r;
        A_VIDL: rdata_nxt = vidl_r;
        A_VIDH: rdata_nxt = vidh_r;
        A_LEN: rdata_nxt = len_r;
        A_STAT: rdata_nxt = stat_r;
        A_MASK: rdata_nxt = mask_r;
        A_CTRL: rdata_nxt = {7'h00, clko_en_r};
        A_STATE: rdata_nxt = {6'h00, int_s2_r, st_r == S_SEND};
        default: rdata_nxt = 8'h00;
      endcase
    end
  end

  always_comb begin
    cfg_nxt.serial_en = set4_r[B_SER];
    cfg_nxt.sec_locked = set4_r[B_LOCK];
    cfg_nxt.sec_password = !set4_r[B_LOCK] && set4_r[B_PWD];
    cfg_nxt.dac_lvl = set6_r[7:6];
    cfg_nxt.dac_internal = set6_r[B_DINT];
    cfg_nxt.dac_powerup = set6_r[4:0];
    cfg_nxt.adc_lvl = set7_r[4:3];
    cfg_nxt.adc_supply = set7_r[B_ASUP];
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      st_r <= S_IDLE;
      ready_r <= 1'b0;
      ok_r <= 1'b0;
      idx_r <= IDX_CMD;
      rsp_r <= '0;
    end else begin
      st_r <= st_nxt;
      ready_r <= st_nxt == S_IDLE;
      if (accept) begin
        ok_r <= sub_ok;
      end
      idx_r <= st_r == S_SEND ? idx_r + 6'h01 : IDX_CMD;
      rsp_r <= rsp_nxt;
    end
  end

  // Reserved bits are dropped on write so they read back as zero
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      set4_r <= RST_SET;
      set5_r <= RST_SET;
      set6_r <= RST_SET;
      set7_r <= RST_SET;
      vidl_r <= RST_VIDL;
      vidh_r <= RST_VIDH;
      len_r <= RST_LEN;
      mask_r <= 8'h00;
      clko_en_r <= 1'b0;
    end else if (WR) begin
      if (ADDR == A_SET4) set4_r <= WDATA & M_SET4;
      if (ADDR == A_SET5) set5_r <= WDATA & M_SET5;
      if (ADDR == A_SET6) set6_r <= WDATA;
      if (ADDR == A_SET7) set7_r <= WDATA & M_SET7;
      if (ADDR == A_VIDL) vidl_r <= WDATA;
      if (ADDR == A_VIDH) vidh_r <= WDATA;
      if (ADDR == A_LEN) len_r <= WDATA;
      if (ADDR == A_MASK) mask_r <= WDATA & M_EVT;
      if (ADDR == A_CTRL) clko_en_r <= WDATA[0];
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      stat_r <= 8'h00;
      irq_r <= 1'b0;
      rdata_r <= 8'h00;
      cfg_r <= '0;
    end else begin
      stat_r <= stat_nxt;
      irq_r <= |(stat_nxt & mask_r);
      rdata_r <= rdata_nxt;
      cfg_r <= cfg_nxt;
    end
  end

  // Interrupt pin: two-stage sync, third stage only for the edge
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      int_s1_r <= 1'b0;
      int_s2_r <= 1'b0;
      int_s3_r <= 1'b0;
    end else begin
      int_s1_r <= INT_PIN;
      int_s2_r <= int_s1_r;
      int_s3_r <= int_s2_r;
    end
  end

  // Clock pin toggles once per divider count; zero stops it
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      div_cnt_r <= 5'h00;
      clk_out_r <= 1'b0;
    end else if (!clko_en_r || set5_r[4:0] == 5'h00) begin
      div_cnt_r <= 5'h00;
      clk_out_r <= 1'b0;
    end else if (div_wrap) begin
      div_cnt_r <= 5'h00;
      clk_out_r <= !clk_out_r;
    end else begin
      div_cnt_r <= div_cnt_r + DIV_ONE;
    end
  end

  assign CMD_READY = ready_r;
  assign RSP = rsp_r;
  assign RDATA = rdata_r;
  assign CLK_OUT = clk_out_r;
  assign CFG = cfg_r;
  assign IRQ = irq_r;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  echo_byte_a: assert property (
    rsp_r.valid && rsp_r.idx == IDX_CMD |-> rsp_r.data == CMD_RDFLASH)
    else $error("command echo wrong");
  status_ok_a: assert property (
    accept && sub_ok |-> ##3 rsp_r.idx == IDX_ST && rsp_r.data == ST_OK)
    else $error("success status wrong");
  unsup_st_a: assert property (
    accept && !sub_ok |-> ##3 rsp_r.idx == IDX_ST && rsp_r.data == ST_UNSUP)
    else $error("unsupported status wrong");
  len_byte_a: assert property (
    rsp_r.valid && rsp_r.idx == IDX_LEN && ok_r |-> rsp_r.data == len_r)
    else $error("length byte wrong");
  undef_zero_a: assert property (
    rsp_r.valid && (rsp_r.idx > IDX_VIDH || !ok_r && rsp_r.idx > IDX_ST)
    |-> rsp_r.data == 8'h00)
    else $error("payload not zero");
  vid_order_a: assert property (
    rsp_r.valid && rsp_r.idx == IDX_VIDL && ok_r
    |-> rsp_r.data == vidl_r ##1 rsp_r.data == vidh_r)
    else $error("vendor id order wrong");
  one_report_a: assert property (
    accept |=> !CMD_READY ##1 rsp_r.valid && rsp_r.idx == IDX_CMD
    ##63 rsp_r.last && rsp_r.idx == IDX_LAST)
    else $error("report length wrong");
  rise_flag_a: assert property (
    rise && set7_r[B_RISE] |=> stat_r[EV_EDGE])
    else $error("rising edge missed");
  fall_flag_a: assert property (
    fall && set7_r[B_FALL] |=> stat_r[EV_EDGE])
    else $error("falling edge missed");
  ref_sel_a: assert property (
    ##1 CFG.dac_internal == $past(set6_r[B_DINT])
    && CFG.adc_supply == $past(set7_r[B_ASUP]))
    else $error("reference select wrong");
  ready_busy_a: assert property (
    st_r == S_SEND |-> !CMD_READY)
    else $error("ready high while sending");
  clk_stop_a: assert property (
    !clko_en_r |=> !CLK_OUT)
    else $error("clock pin not stopped");
  serial_bit_a: assert property (
    ##1 CFG.serial_en == $past(set4_r[B_SER]))
    else $error("serial enable wrong");

  chip_rsp_c: cover property (accept && sub_ok);
  unsup_rsp_c: cover property (accept && !sub_ok);
  back_to_back_c: cover property (rsp_r.last ##1 accept);
  edge_irq_c: cover property (edge_hit ##1 IRQ);
  clk_out_c: cover property ($rose(CLK_OUT));
endmodule : frf_top

// ===== testbench/frf_host_model.sv
`timescale 1ns/10ps
module frf_host_model
  import frf_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic cmd_ready,
  input wire frf_pkg::frf_rsp_t rsp,
  output frf_pkg::frf_cmd_t cmd,
  output logic [7:0] rx [0:63],
  output int got,
  output logic ord_bad
);
  initial cmd = '0;
  // Bytes 3 and the loose bits are captured but carry no meaning here
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      got <= 0;
      ord_bad <= 1'b0;
    end else if (rsp.valid === 1'b1) begin
      rx[rsp.idx] <= rsp.data;
      if (rsp.idx !== 6'(got) || rsp.last !== (rsp.idx == IDX_LAST)) begin
        ord_bad <= 1'b1;
      end
      got <= got + 1;
    end
  end
  // Off-frame code and sub show the inverse of the last value
  task automatic send(input logic [7:0] code, input logic [7:0] sub);
    while (cmd_ready !== 1'b1) @(negedge clk);
    @(posedge clk);
    cmd <= '{valid: 1'b1, code: code, sub: sub};
    @(posedge clk);
    cmd <= '{valid: 1'b0, code: ~code, sub: ~sub};
  endtask : send
endmodule : frf_host_model

// ===== testbench/frf_top_tb.sv
`timescale 1ns/10ps
module frf_top_tb;
  import frf_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] addr = '0;
  logic [7:0] wdata = '0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic int_pin = 1'b0;
  logic cmd_ready;
  logic irq;
  logic clk_out;
  logic ord_bad;
  logic [7:0] rdata;
  logic [7:0] rx [0:63];
  logic [7:0] regm [0:6];
  frf_cmd_t cmd;
  frf_rsp_t rsp;
  frf_cfg_t cfg;
  frf_cfg_t ecfg;
  int got;
  int n;
  int dv;
  logic co;
  int error_cnt = 0;
  int comparisons = 0;
  always #5 clk = ~clk;
  frf_top u_dut (.CLK(clk), .RST(rst), .CMD(cmd), .CMD_READY(cmd_ready),
    .RSP(rsp), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .INT_PIN(int_pin), .CLK_OUT(clk_out), .CFG(cfg),
    .IRQ(irq));
  frf_host_model u_host (.clk(clk), .rst(rst), .cmd_ready(cmd_ready),
    .rsp(rsp), .cmd(cmd), .rx(rx), .got(got), .ord_bad(ord_bad));
  task automatic chk(input string what, input logic [15:0] e,
      input logic [15:0] s);
    comparisons++;
    if (s !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, e, s);
    end
  endtask : chk
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk("rdata", {4'h0, a, e}, {4'h0, a, rdata});
  endtask : rd_chk
  task automatic rsp_chk(input logic [7:0] sub);
    int base;
    logic [7:0] e;
    base = got;
    u_host.send(CMD_RDFLASH, sub);
    for (int k = 0; k < 200 && got < base + 64; k++) @(posedge clk);
    chk("count", 16'(base + 64), 16'(got));
    for (int i = 0; i < 64; i++) begin
      e = 8'h00;
      if (i == 0) e = 8'hb0;
      else if (i == 1) e = (sub == 8'h00) ? 8'h00 : 8'h01;
      else if (sub == 8'h00 && i == 2) e = regm[6];
      else if (sub == 8'h00 && i >= 4 && i <= 9) e = regm[i - 4];
      chk("rsp", {8'(i), e}, {8'(i), rx[i]});
    end
  endtask : rsp_chk
  task automatic tally_and_finish;
    if (error_cnt == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : tally_and_finish
  task automatic edge_chk(input logic lvl, input logic [7:0] e);
    int_pin <= lvl;
    repeat (6) @(posedge clk);
    rd_chk(4'h7, e);
    wr_reg(4'h7, 8'h07);
  endtask : edge_chk
  initial begin
    repeat (5000) @(posedge clk);
    error_cnt++;
    tally_and_finish;
  end
  initial begin
    void'($urandom(32'h2fbfceff));
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    for (int a = 0; a < 7; a++) begin
      regm[a] = 8'($urandom);
      wr_reg(4'(a), regm[a]);
    end
    regm[0] = regm[0] & M_SET4;
    regm[1] = regm[1] & M_SET5;
    regm[3] = regm[3] & M_SET7;
    wr_reg(4'hf, 8'hff);
    for (int a = 0; a < 7; a++) rd_chk(4'(a), regm[a]);
    rd_chk(4'hf, 8'h00);
    ecfg.serial_en = regm[0][7];
    ecfg.sec_locked = regm[0][1];
    ecfg.sec_password = (regm[0][1:0] == 2'b01);
    ecfg.dac_lvl = regm[2][7:6];
    ecfg.dac_internal = regm[2][5];
    ecfg.dac_powerup = regm[2][4:0];
    ecfg.adc_lvl = regm[3][4:3];
    ecfg.adc_supply = regm[3][2];
    chk("cfg", 16'(ecfg), 16'(cfg));
    rsp_chk(SUB_CHIP);
    for (int s = 1; s < 6; s++) rsp_chk(8'(s));
    rsp_chk(8'($urandom_range(255, 6)));
    rsp_chk(SUB_CHIP);
    n = got;
    u_host.send(8'h10, SUB_CHIP);
    repeat (80) @(posedge clk);
    chk("ignored", 16'(n), 16'(got));
    chk("order", 16'h0, 16'(ord_bad));
    rd_chk(4'h7, 8'h03);
    chk("irq", 16'h0, 16'(irq));
    wr_reg(4'h8, 8'h07);
    repeat (3) @(posedge clk);
    chk("irq", 16'h1, 16'(irq));
    wr_reg(4'h7, 8'h03);
    repeat (3) @(posedge clk);
    chk("irq", 16'h0, 16'(irq));
    wr_reg(4'h3, 8'h20);
    edge_chk(1'b1, 8'h04);
    edge_chk(1'b0, 8'h00);
    wr_reg(4'h3, 8'h40);
    edge_chk(1'b1, 8'h00);
    rd_chk(4'ha, 8'h02);
    edge_chk(1'b0, 8'h04);
    dv = $urandom_range(31, 1);
    wr_reg(4'h1, 8'(dv));
    wr_reg(4'h9, 8'h01);
    rd_chk(4'h9, 8'h01);
    // First pass finds a toggle, second counts one full half period
    for (int p = 0; p < 2; p++) begin
      co = clk_out;
      n = 0;
      while (clk_out === co && n < 40) begin
        @(posedge clk);
        n++;
      end
    end
    chk("clk_out", 16'(dv), 16'(n));
    wr_reg(4'h9, 8'h00);
    repeat (2) @(posedge clk);
    chk("clk_out", 16'h0, 16'(clk_out));
    tally_and_finish;
  end
endmodule : frf_top_tb
